// >>> rtl/bit_ops_pkg.sv
// Shared types and constants for the indexed bit instruction datapath
package bit_ops_pkg;
  localparam int WORD_W = 32;
  localparam int IDX_W = 5;
  localparam logic [4:0] IDX_MAX_16 = 5'h0f;
  localparam logic [4:0] IDX_MAX_32 = 5'h1f;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [8:0] FC_DRIVE = 9'h10a;
  localparam logic [8:0] FC_FORCE_ON = 9'h10b;
  localparam logic [8:0] FC_FORCE_OFF = 9'h10c;
  localparam logic [8:0] FC_LOAD_NORMAL = 9'h10d;
  localparam logic [8:0] FC_LOAD_INVERTED = 9'h10e;

  // One instruction issued by the sequencer
  typedef struct packed {
    logic valid;
    logic [8:0] func;
    logic wide;
    logic rung;
    logic [4:0] idx;
    logic [31:0] word;
  } bit_req_t;

  // Result returned to the sequencer and the word store
  typedef struct packed {
    logic done;
    logic idx_err;
    logic contact;
    logic wr_en;
    logic [31:0] word;
  } bit_rsp_t;
endpackage : bit_ops_pkg

// >>> rtl/bit_select.sv
// One-hot decode of the bit index and selected-bit extraction
module bit_select (
  input wire logic [4:0] i_idx,
  input wire logic i_wide,
  input wire logic [31:0] i_word,
  output logic [31:0] o_onehot,
  output logic o_bit,
  output logic o_range_ok
);
  // Narrow form only reaches the low half of the word
  assign o_range_ok = i_wide ? (i_idx <= bit_ops_pkg::IDX_MAX_32)
                             : (i_idx <= bit_ops_pkg::IDX_MAX_16);

  // Index used directly as bit position
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_dec
      assign o_onehot[g] = o_range_ok && (i_idx == 5'(g));
    end
  endgenerate

  assign o_bit = |(o_onehot & i_word);
endmodule : bit_select

// >>> rtl/bit_word_ops.sv
// Execution unit for indexed bit drive, force and load instructions
//
// How it works
// - The index accepts 0..15 in the 16-bit form and 0..31 in the 32-bit form.
// - The drive operation writes the rung result into the indexed bit.
// - Index 0 picks the lowest bit and the index value is the bit position.
// - A false drive gives coil off, open contact blocked, closed contact conducting.
// - The force-on operation sets the indexed bit to one.
// - A forced-on bit stays one until a force-off or a false drive on that bit clears it.
// - The force-off operation clears the indexed bit to zero.
// - The normal load yields true when the indexed source bit is one.
// - The inverted load starts a rung from a closed contact on the indexed bit.
// - The inverted load yields true when the indexed source bit is zero.
module bit_word_ops (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire bit_ops_pkg::bit_req_t i_req,
  output bit_ops_pkg::bit_rsp_t o_rsp,
  output logic o_coil,
  output logic o_no_contact,
  output logic o_nc_contact
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  logic [31:0] onehot;
  logic sel_bit;
  logic range_ok;

  bit_select u_sel (
    .i_idx(i_req.idx),
    .i_wide(i_req.wide),
    .i_word(i_req.word),
    .o_onehot(onehot),
    .o_bit(sel_bit),
    .o_range_ok(range_ok)
  );

  wire is_drive = i_req.valid && i_req.func == bit_ops_pkg::FC_DRIVE;
  wire is_on = i_req.valid && i_req.func == bit_ops_pkg::FC_FORCE_ON;
  wire is_off = i_req.valid && i_req.func == bit_ops_pkg::FC_FORCE_OFF;
  wire is_ldn = i_req.valid && i_req.func == bit_ops_pkg::FC_LOAD_NORMAL;
  wire is_ldi = i_req.valid && i_req.func == bit_ops_pkg::FC_LOAD_INVERTED;
  wire is_any = is_drive | is_on | is_off | is_ldn | is_ldi;
  // Narrow form keeps the upper half untouched
  wire [31:0] keep_mask = i_req.wide ? 32'h0000_0000 : 32'hffff_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Next word and contact result

  // Out-of-range index writes nothing: safer than wrapping onto a wrong coil
  wire do_write = range_ok && (is_drive || ((is_on || is_off) && i_req.rung));
  wire [31:0] drive_word = i_req.rung ? (i_req.word | onehot)
                                      : (i_req.word & ~onehot);
  wire [31:0] on_word = i_req.word | onehot;
  wire [31:0] off_word = i_req.word & ~onehot;
  wire [31:0] raw_word = is_drive ? drive_word : (is_on ? on_word : off_word);
  wire [31:0] word_next = raw_word & ~keep_mask | (i_req.word & keep_mask);
  wire contact_next = range_ok && (is_ldn ? sel_bit : ~sel_bit);
  wire coil_next = is_drive ? (range_ok && i_req.rung) : o_coil;

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  // Response valid one cycle after the request
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rsp <= '0;
      o_coil <= 1'b0;
      o_no_contact <= 1'b0;
      o_nc_contact <= 1'b1;
    end else begin
      o_rsp.done <= is_any;
      o_rsp.idx_err <= is_any && !range_ok;
      o_rsp.contact <= (is_ldn || is_ldi) ? contact_next : 1'b0;
      o_rsp.wr_en <= do_write;
      o_rsp.word <= do_write ? word_next : bit_ops_pkg::WORD_RST;
      o_coil <= coil_next;
      o_no_contact <= coil_next;
      o_nc_contact <= ~coil_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_drive_bit;
    @(posedge i_mclk) disable iff (!i_nrst)
    (is_drive && range_ok) |=> o_rsp.wr_en && (o_rsp.word[$past(i_req.idx)] == $past(i_req.rung));
  endproperty
  a_drive_bit: assert property (p_drive_bit) else $error("drive bit wrong");

  property p_force_on;
    @(posedge i_mclk) disable iff (!i_nrst)
    (is_on && range_ok && i_req.rung) |=> o_rsp.word[$past(i_req.idx)];
  endproperty
  a_force_on: assert property (p_force_on) else $error("force on failed");

  property p_force_off;
    @(posedge i_mclk) disable iff (!i_nrst)
    (is_off && range_ok && i_req.rung) |=> o_rsp.wr_en && !o_rsp.word[$past(i_req.idx)];
  endproperty
  a_force_off: assert property (p_force_off) else $error("force off failed");

  // Registered copy of the decode, so the check compares against the taken index
  logic [31:0] onehot_q;

  property p_hold_others;
    @(posedge i_mclk) disable iff (!i_nrst)
    (is_on && range_ok && i_req.rung) |=>
      ((o_rsp.word | onehot_q) == ($past(i_req.word) | onehot_q));
  endproperty
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) onehot_q <= '0;
    else onehot_q <= onehot;
  end
  a_hold_others: assert property (p_hold_others) else $error("other bits disturbed");

  property p_rung_gate;
    @(posedge i_mclk) disable iff (!i_nrst)
    ((is_on || is_off) && !i_req.rung) |=> !o_rsp.wr_en;
  endproperty
  a_rung_gate: assert property (p_rung_gate) else $error("write without rung");

  property p_load_normal;
    @(posedge i_mclk) disable iff (!i_nrst)
    (is_ldn && range_ok) |=> o_rsp.done && (o_rsp.contact == $past(i_req.word[i_req.idx]));
  endproperty
  a_load_normal: assert property (p_load_normal) else $error("normal load wrong");

  property p_load_inv;
    @(posedge i_mclk) disable iff (!i_nrst)
    (is_ldi && range_ok) |=> (o_rsp.contact != $past(i_req.word[i_req.idx]));
  endproperty
  a_load_inv: assert property (p_load_inv) else $error("inverted load wrong");

  property p_range;
    @(posedge i_mclk) disable iff (!i_nrst)
    (is_any && !i_req.wide && i_req.idx[4]) |=> o_rsp.idx_err && !o_rsp.wr_en;
  endproperty
  a_range: assert property (p_range) else $error("narrow index not refused");

  property p_contacts;
    @(posedge i_mclk) disable iff (!i_nrst)
    (o_no_contact == o_coil) && (o_nc_contact != o_coil);
  endproperty
  a_contacts: assert property (p_contacts) else $error("contact states wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Multi-step checks

  // Gated force: request taken on a true rung, then a written answer
  sequence s_force_req;
    (is_on || is_off) && range_ok && i_req.rung;
  endsequence

  sequence s_written;
    o_rsp.done && o_rsp.wr_en;
  endsequence

  // A taken force with a true rung always hands back a word to store
  property p_force_writes;
    @(posedge i_mclk) disable iff (!i_nrst)
    s_force_req |=> s_written;
  endproperty
  a_force_writes: assert property (p_force_writes) else $error("force not written");

  // Every known code answers exactly one cycle later
  property p_done_once;
    @(posedge i_mclk) disable iff (!i_nrst)
    is_any |=> o_rsp.done;
  endproperty
  a_done_once: assert property (p_done_once) else $error("no done after request");

  // Unknown codes are ignored, so a stray word never reaches the store
  property p_refuse_func;
    @(posedge i_mclk) disable iff (!i_nrst)
    (i_req.valid && !is_any) |=> !o_rsp.done && !o_rsp.wr_en;
  endproperty
  a_refuse_func: assert property (p_refuse_func) else $error("unknown code answered");

  // Index is the plain bit position, no offset or reversal
  property p_index_pos;
    @(posedge i_mclk) disable iff (!i_nrst)
    (is_drive && range_ok && i_req.rung) |=>
      (o_rsp.word == ($past(i_req.word) | (32'h1 << $past(i_req.idx))));
  endproperty
  a_index_pos: assert property (p_index_pos) else $error("index not bit position");

  // Coil is a level: only a drive may move it
  property p_coil_hold;
    @(posedge i_mclk) disable iff (!i_nrst)
    !is_drive |=> $stable(o_coil);
  endproperty
  a_coil_hold: assert property (p_coil_hold) else $error("coil moved without drive");

  // Out-of-range drive fails safe: coil off and nothing written
  property p_drive_oor;
    @(posedge i_mclk) disable iff (!i_nrst)
    (is_drive && !range_ok) |=> !o_coil && !o_rsp.wr_en;
  endproperty
  a_drive_oor: assert property (p_drive_oor) else $error("bad index drove coil");

  // A refused index carries no contact result and no write
  property p_err_quiet;
    @(posedge i_mclk) disable iff (!i_nrst)
    o_rsp.idx_err |-> !o_rsp.contact && !o_rsp.wr_en;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("refused index not quiet");

  // Narrow form leaves the upper half of the stored word alone
  property p_narrow_keep;
    @(posedge i_mclk) disable iff (!i_nrst)
    (is_any && !i_req.wide) |=>
      (!o_rsp.wr_en || (o_rsp.word[31:16] == $past(i_req.word[31:16])));
  endproperty
  a_narrow_keep: assert property (p_narrow_keep) else $error("upper half disturbed");

  // Loads only read, they must never write the store back
  property p_load_no_write;
    @(posedge i_mclk) disable iff (!i_nrst)
    (is_ldn || is_ldi) |=> !o_rsp.wr_en;
  endproperty
  a_load_no_write: assert property (p_load_no_write) else $error("load wrote word");

  // Closed contact on a clear bit starts the rung true
  property p_ldi_start;
    @(posedge i_mclk) disable iff (!i_nrst)
    (is_ldi && range_ok && !sel_bit) |=> o_rsp.contact;
  endproperty
  a_ldi_start: assert property (p_ldi_start) else $error("closed contact not true");

endmodule : bit_word_ops

// >>> dv/word_store.sv
// Partner model: device word storage fed back to the bit datapath
module word_store (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_wr_en,
  input wire logic [31:0] i_word,
  output logic [31:0] o_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // Word holds until written, so a forced bit stays latched
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) o_word <= 32'h0;
    else if (i_wr_en) o_word <= i_word;
  end
endmodule : word_store

// >>> dv/test_bit_word_ops.sv
// Self-checking bench for the indexed bit datapath
module test_bit_word_ops;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk, i_nrst, v, wd, rg, o_coil, o_no_contact, o_nc_contact;
  logic [8:0] fc;
  logic [4:0] ix;
  logic [31:0] mem;
  bit_ops_pkg::bit_rsp_t o_rsp, rsp;
  int num_errors, checked, cyc;
  ////////////////////////////////////////////////////////////////
  bit_word_ops dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_req({v, fc, wd, rg, ix, mem}),
    .o_rsp(o_rsp), .o_coil(o_coil), .o_no_contact(o_no_contact), .o_nc_contact(o_nc_contact));
  word_store store (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_wr_en(o_rsp.wr_en),
    .i_word(o_rsp.word), .o_word(mem));
  // Clock and a hang guard well past the few dozen cycles needed
  initial begin
    i_mclk = 0;
    forever #20 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////
  task results();
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask : chk
  // One instruction; word comes live from the store, answer one cycle on
  task op(input logic [8:0] f, input logic w, input logic r, input logic [4:0] x);
    @(posedge i_mclk);
    v <= 1;
    fc <= f;
    wd <= w;
    rg <= r;
    ix <= x;
    @(posedge i_mclk);
    v <= 0;
    #1 rsp = o_rsp;
    chk("done", 32'h1, rsp.done);
    @(posedge i_mclk);
    #1;
  endtask : op
  ////////////////////////////////////////////////////////////////
  task t_force();
    op(9'h10b, 0, 1, 5'h00);
    chk("on0", 32'h1, mem);
    op(9'h10b, 1, 1, 5'h1f);
    chk("on31", 32'h8000_0001, mem);
    op(9'h10b, 0, 0, 5'h05);
    chk("norung", 32'h0, rsp.wr_en);
    op(9'h10d, 1, 0, 5'h00);
    chk("latch", 32'h1, rsp.contact);
    op(9'h10c, 0, 1, 5'h00);
    chk("off0", 32'h8000_0000, mem);
  endtask : t_force
  task t_drive();
    op(9'h10a, 0, 1, 5'h04);
    chk("drv1", 32'h8000_0010, mem);
    chk("coil1", 32'h6, {o_coil, o_no_contact, o_nc_contact});
    op(9'h10a, 0, 0, 5'h04);
    chk("drv0", 32'h8000_0000, mem);
    chk("coil0", 32'h1, {o_coil, o_no_contact, o_nc_contact});
  endtask : t_drive
  task t_load();
    op(9'h10d, 1, 0, 5'h1f);
    chk("ld1", 32'h1, rsp.contact);
    op(9'h10d, 0, 0, 5'h04);
    chk("ld0", 32'h0, rsp.contact);
    op(9'h10e, 0, 0, 5'h04);
    chk("ldi1", 32'h1, rsp.contact);
    op(9'h10e, 1, 0, 5'h1f);
    chk("ldi0", 32'h0, rsp.contact);
  endtask : t_load
  task t_range();
    op(9'h10b, 0, 1, 5'h10);
    chk("err", 32'h2, {rsp.idx_err, rsp.wr_en});
    chk("keep", 32'h8000_0000, mem);
  endtask : t_range
  // Reset for two cycles, then the scenarios
  initial begin
    i_nrst = 0;
    v = 0;
    fc = 9'h0;
    wd = 0;
    rg = 0;
    ix = 5'h0;
    repeat (2) @(posedge i_mclk);
    i_nrst <= 1;
    t_force();
    t_drive();
    t_load();
    t_range();
    results();
  end
endmodule : test_bit_word_ops
